//--- design/qrpc_defines.vh
// Purpose: Shared constants of the read-parameter and reset controller.
// Assumes: 20 MHz pclk, byte addressed APB with one word per register.
// Notes: Each rule below is kept by the logic; no rule carries a tag.
// Function
// - Four-wire mode: C0h sets dummy and wrap.
// - Serial mode: C0h rejected, settings unchanged.
// - Serial fast reads use fixed dummy counts.
// - Serial mode: wrap length from 77h bits.
// - Mode switch keeps write latch and wrap.
// - Reset defaults: wrap 8 bytes, dummy 2.
// - Wrap field 00/01/10/11 gives 8/16/32/64.
// - Wrapped read returns to window start.
// - One mode at once; 38h enters four-wire.
// - Power-up starts in serial mode.
// - FFh in four-wire returns to serial.
// - Reset aborts work, clears volatile settings.
// - Reset only when 66h directly precedes 99h.
// - Other command after 66h disarms reset.
// - About 30 us resetting, commands ignored.
// - Write-in-progress reads 1 while busy.
`ifndef QRPC_DEFINES_VH
`define QRPC_DEFINES_VH

`define QRPC_OP_SET_PARAM 8'hc0
`define QRPC_OP_SET_WRAP  8'h77
`define QRPC_OP_FAST_RD   8'h0b
`define QRPC_OP_QIO_RD    8'heb
`define QRPC_OP_WRAP_RD   8'h0c
`define QRPC_OP_ENTER_4W  8'h38
`define QRPC_OP_EXIT_4W   8'hff
`define QRPC_OP_RST_EN    8'h66
`define QRPC_OP_RST       8'h99
`define QRPC_OP_WR_EN     8'h06
`define QRPC_OP_WR_DIS    8'h04
`define QRPC_OP_RD_STAT   8'h05

`define QRPC_SER_FAST_DUMMY 4'h8
`define QRPC_SER_QIO_DUMMY  4'h6

`define QRPC_RST_PARAM 8'h00
`define QRPC_RST_WRAP  2'h0

`define QRPC_T_RST_NS 30000

`define QRPC_REG_STATUS 8'h00
`define QRPC_REG_CTRL   8'h04
`define QRPC_REG_PARAM  8'h08

`define QRPC_ST_WR_BUSY  0
`define QRPC_ST_WR_LATCH 1
`define QRPC_ST_4W    2
`define QRPC_ST_ARMED 3
`define QRPC_ST_RBUSY 4

`define QRPC_CT_OP    0
`define QRPC_CT_VOL_L 8

`define QRPC_PA_RP_L   0
`define QRPC_PA_WS_L   8
`define QRPC_PA_CM_L   16
`define QRPC_PA_DUM_L  24
`define QRPC_PA_WRAP_L 28

`endif

//--- design/qrpc_sync.v
// Purpose: Two-stage synchroniser for pins entering the pclk domain.
// Assumes: Inputs are asynchronous levels.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ns
module qrpc_sync #(
	parameter W = 6
)(
	// Clock and reset.
	input  wire         pclk,
	input  wire         presetn,
	// Pins in and synchronised out.
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);

reg [W-1:0] meta_ff;

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		meta_ff <= {W{1'b1}};
		dout    <= {W{1'b1}};
	end
	else
	begin
		meta_ff <= din;
		dout    <= meta_ff;
	end
end

endmodule

//--- design/qrpc_ctl.v
// Purpose: Serial flash command layer for modes, read parameters and reset.
// Assumes: Link pins are sampled by pclk; sclk is slow against pclk.
// Notes: Array content is read through array_addr and array_data.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
`include "qrpc_defines.vh"
module qrpc_ctl #(
	parameter CLK_NS = 50
)(
	// Clock and reset.
	input  wire        pclk,
	input  wire        presetn,
	// APB slave.
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Serial link.
	input  wire        cs_n,
	input  wire        sclk,
	input  wire [3:0]  dq_in,
	output reg  [3:0]  dq_out,
	output wire [3:0]  dq_oe,
	// Array read port.
	output wire [23:0] array_addr,
	input  wire [7:0]  array_data
);

localparam [31:0] RST_CYC = (`QRPC_T_RST_NS + CLK_NS - 1) / CLK_NS;

localparam [2:0] S_CMD   = 3'd0;
localparam [2:0] S_ADDR  = 3'd1;
localparam [2:0] S_PARAM = 3'd2;
localparam [2:0] S_DUMMY = 3'd3;
localparam [2:0] S_DATA  = 3'd4;
localparam [2:0] S_IGN   = 3'd5;

// Dummy field decode.
function [3:0] dummy_clocks;
	input [1:0] f;
	begin
		case (f)
			2'b00: dummy_clocks = 4'h2;
			2'b01: dummy_clocks = 4'h4;
			2'b10: dummy_clocks = 4'h6;
			default: dummy_clocks = 4'h8;
		endcase
	end
endfunction

// Wrap field decode into an offset mask.
function [5:0] wrap_mask;
	input [1:0] f;
	begin
		case (f)
			2'b00: wrap_mask = 6'h07;
			2'b01: wrap_mask = 6'h0f;
			2'b10: wrap_mask = 6'h1f;
			default: wrap_mask = 6'h3f;
		endcase
	end
endfunction

// Next read address, optionally held inside the aligned window.
function [23:0] next_addr;
	input [23:0] a;
	input        wrap;
	input [5:0]  m;
	reg   [23:0] inc;
	reg   [23:0] wm;
	begin
		inc = a + 24'h000001;
		wm  = {18'h00000, m};
		if (wrap)
			next_addr = (a & ~wm) | (inc & wm);
		else
			next_addr = inc;
	end
endfunction

wire [5:0] sync_q;
wire       cs_s;
wire       sclk_s;
wire [3:0] dq_s;

qrpc_sync #(
	.W (6)
) u_sync (
	.pclk    (pclk),
	.presetn (presetn),
	.din     ({cs_n, sclk, dq_in}),
	.dout    (sync_q)
);

assign cs_s   = sync_q[5];
assign sclk_s = sync_q[4];
assign dq_s   = sync_q[3:0];

reg        sclk_d_ff;
reg        cs_d_ff;
reg [2:0]  st_ff;
reg [7:0]  cmd_ff;
reg [7:0]  sh_ff;
reg [3:0]  bitcnt_ff;
reg [1:0]  bcnt_ff;
reg [3:0]  dcnt_ff;
reg [2:0]  ocnt_ff;
reg [7:0]  ob_ff;
reg [23:0] addr_ff;
reg        got_ff;
reg        four_wire_ff;
reg        write_enable_latch_ff;
reg        armed_ff;
reg [7:0]  rp_ff;
reg [1:0]  wrap_len_ff;
reg [2:0]  wrap_set_ff;
reg [7:0]  cont_mode_ff;
reg        op_busy_ff;
reg [7:0]  vol_ff;
reg [15:0] rst_cnt_ff;

wire       rst_busy  = (rst_cnt_ff != 16'h0000);
wire       sclk_rise = sclk_s & ~sclk_d_ff & ~cs_s;
wire       sclk_fall = ~sclk_s & sclk_d_ff & ~cs_s;
wire       cs_rise   = cs_s & ~cs_d_ff;
wire       is_qio    = (cmd_ff == `QRPC_OP_QIO_RD);
wire       in_quad   = four_wire_ff | (st_ff != S_CMD & is_qio);
wire       out_quad  = four_wire_ff | is_qio;
wire [3:0] bit_inc   = in_quad ? 4'h4 : 4'h1;
wire [3:0] bit_nxt   = bitcnt_ff + bit_inc;
wire       byte_done = sclk_rise & (bit_nxt == 4'h8);
wire [7:0] in_byte   = in_quad ? {sh_ff[3:0], dq_s} : {sh_ff[6:0], dq_s[0]};
wire [7:0] stat_byte = {vol_ff[7:2], write_enable_latch_ff,
		op_busy_ff};
wire [7:0] src_byte  = (cmd_ff == `QRPC_OP_RD_STAT) ? stat_byte
		: array_data;
wire [2:0] o_last    = out_quad ? 3'd1 : 3'd7;
wire       wrap_rd   = (cmd_ff == `QRPC_OP_WRAP_RD);
wire [3:0] dum_len   = four_wire_ff ? dummy_clocks(rp_ff[5:4])
		: (is_qio ? `QRPC_SER_QIO_DUMMY : `QRPC_SER_FAST_DUMMY);
wire       apb_wr    = psel & penable & pwrite;
wire       hit       = (paddr == `QRPC_REG_STATUS) |
		(paddr == `QRPC_REG_CTRL) | (paddr == `QRPC_REG_PARAM);
wire       do_reset  = cs_rise & got_ff & (cmd_ff == `QRPC_OP_RST) &
		armed_ff;

assign array_addr = addr_ff;
assign dq_oe      = (st_ff == S_DATA && !cs_s) ?
		(out_quad ? 4'hf : 4'h2) : 4'h0;
assign pready     = 1'b1;
assign pslverr    = psel & penable & ~hit;

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		sclk_d_ff    <= 1'b1;
		cs_d_ff      <= 1'b1;
		st_ff        <= S_CMD;
		cmd_ff       <= 8'h00;
		sh_ff        <= 8'h00;
		bitcnt_ff    <= 4'h0;
		bcnt_ff      <= 2'h0;
		dcnt_ff      <= 4'h0;
		ocnt_ff      <= 3'h0;
		ob_ff        <= 8'h00;
		dq_out       <= 4'h0;
		addr_ff      <= 24'h000000;
		got_ff       <= 1'b0;
		four_wire_ff <= 1'b0;
		write_enable_latch_ff <= 1'b0;
		armed_ff     <= 1'b0;
		rp_ff        <= `QRPC_RST_PARAM;
		wrap_len_ff  <= `QRPC_RST_WRAP;
		wrap_set_ff  <= 3'h0;
		cont_mode_ff <= 8'h00;
		op_busy_ff   <= 1'b0;
		vol_ff       <= 8'h00;
		rst_cnt_ff   <= 16'h0000;
	end
	else
	begin
		sclk_d_ff <= sclk_s;
		cs_d_ff   <= cs_s;
		if (apb_wr && paddr == `QRPC_REG_CTRL)
		begin
			op_busy_ff <= pwdata[`QRPC_CT_OP];
			vol_ff     <= pwdata[`QRPC_CT_VOL_L+7:`QRPC_CT_VOL_L];
		end
		if (rst_busy)
		begin
			rst_cnt_ff <= rst_cnt_ff - 16'h0001;
			if (rst_cnt_ff == 16'h0001)
			begin
				armed_ff     <= 1'b0;
				four_wire_ff <= 1'b0;
			end
		end
		if (cs_s)
		begin
			st_ff     <= S_CMD;
			bitcnt_ff <= 4'h0;
			bcnt_ff   <= 2'h0;
		end
		else if (sclk_rise && st_ff != S_DATA && st_ff != S_IGN)
		begin
			sh_ff     <= in_byte;
			bitcnt_ff <= byte_done ? 4'h0 : bit_nxt;
		end
		if (byte_done)
		begin
			case (st_ff)
				S_CMD:
				begin
					cmd_ff <= in_byte;
					if (rst_busy)
						st_ff <= S_IGN;
					else
					begin
						got_ff <= 1'b1;
						case (in_byte)
							`QRPC_OP_SET_PARAM:
								st_ff <= four_wire_ff ? S_PARAM : S_IGN;
							`QRPC_OP_SET_WRAP:
								st_ff <= four_wire_ff ? S_IGN : S_ADDR;
							`QRPC_OP_FAST_RD:
								st_ff <= S_ADDR;
							`QRPC_OP_QIO_RD:
								st_ff <= S_ADDR;
							`QRPC_OP_WRAP_RD:
								st_ff <= four_wire_ff ? S_ADDR : S_IGN;
							`QRPC_OP_RD_STAT:
								st_ff <= S_DATA;
							default:
								st_ff <= S_IGN;
						endcase
					end
					ocnt_ff <= 3'h0;
				end
				S_ADDR:
				begin
					addr_ff <= {addr_ff[15:0], in_byte};
					bcnt_ff <= bcnt_ff + 2'h1;
					if (bcnt_ff == 2'h2)
					begin
						st_ff   <= (cmd_ff == `QRPC_OP_SET_WRAP) ?
								S_PARAM : S_DUMMY;
						dcnt_ff <= dum_len;
					end
				end
				S_PARAM:
				begin
					if (cmd_ff == `QRPC_OP_SET_PARAM)
					begin
						rp_ff       <= in_byte;
						wrap_len_ff <= in_byte[1:0];
					end
					else
					begin
						wrap_set_ff <= in_byte[6:4];
						wrap_len_ff <= in_byte[5:4];
					end
					st_ff <= S_IGN;
				end
				default:
				begin
					if (st_ff == S_DUMMY && is_qio &&
							dcnt_ff == dum_len - 4'h1)
						cont_mode_ff <= in_byte;
				end
			endcase
		end
		if (sclk_rise && st_ff == S_DUMMY)
		begin
			dcnt_ff <= dcnt_ff - 4'h1;
			if (dcnt_ff == 4'h1)
			begin
				st_ff   <= S_DATA;
				ocnt_ff <= 3'h0;
			end
		end
		if (sclk_fall && st_ff == S_DATA)
		begin
			if (ocnt_ff == 3'h0)
			begin
				dq_out  <= out_quad ? src_byte[7:4] : {2'b00, src_byte[7], 1'b0};
				ob_ff   <= out_quad ? {src_byte[3:0], 4'h0}
						: {src_byte[6:0], 1'b0};
				addr_ff <= next_addr(addr_ff, wrap_rd,
						wrap_mask(wrap_len_ff));
			end
			else
			begin
				dq_out <= out_quad ? ob_ff[7:4] : {2'b00, ob_ff[7], 1'b0};
				ob_ff  <= out_quad ? {ob_ff[3:0], 4'h0} : {ob_ff[6:0], 1'b0};
			end
			ocnt_ff <= (ocnt_ff == o_last) ? 3'h0 : ocnt_ff + 3'h1;
		end
		if (cs_rise && got_ff)
		begin
			got_ff   <= 1'b0;
			armed_ff <= (cmd_ff == `QRPC_OP_RST_EN);
			case (cmd_ff)
				`QRPC_OP_ENTER_4W:
					four_wire_ff <= 1'b1;
				`QRPC_OP_EXIT_4W:
					four_wire_ff <= 1'b0;
				`QRPC_OP_WR_EN:
					write_enable_latch_ff <= 1'b1;
				`QRPC_OP_WR_DIS:
					write_enable_latch_ff <= 1'b0;
				default:
					write_enable_latch_ff <= write_enable_latch_ff;
			endcase
		end
		if (do_reset)
		begin
			rst_cnt_ff   <= RST_CYC[15:0];
			armed_ff     <= 1'b0;
			four_wire_ff <= 1'b0;
			write_enable_latch_ff <= 1'b0;
			rp_ff        <= `QRPC_RST_PARAM;
			wrap_len_ff  <= `QRPC_RST_WRAP;
			wrap_set_ff  <= 3'h0;
			cont_mode_ff <= 8'h00;
			op_busy_ff   <= 1'b0;
			vol_ff       <= 8'h00;
		end
	end
end

// Read data is captured in the setup phase and held through access.
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		prdata <= 32'h00000000;
	else if (psel && !penable && !pwrite)
	begin
		prdata <= 32'h00000000;
		case (paddr)
			`QRPC_REG_STATUS:
			begin
				prdata[`QRPC_ST_WR_BUSY]  <= op_busy_ff;
				prdata[`QRPC_ST_WR_LATCH] <= write_enable_latch_ff;
				prdata[`QRPC_ST_4W]    <= four_wire_ff;
				prdata[`QRPC_ST_ARMED] <= armed_ff;
				prdata[`QRPC_ST_RBUSY] <= rst_busy;
			end
			`QRPC_REG_CTRL:
			begin
				prdata[`QRPC_CT_OP] <= op_busy_ff;
				prdata[`QRPC_CT_VOL_L+7:`QRPC_CT_VOL_L] <= vol_ff;
			end
			`QRPC_REG_PARAM:
			begin
				prdata[`QRPC_PA_RP_L+7:`QRPC_PA_RP_L]     <= rp_ff;
				prdata[`QRPC_PA_WS_L+2:`QRPC_PA_WS_L]     <= wrap_set_ff;
				prdata[`QRPC_PA_CM_L+7:`QRPC_PA_CM_L]     <= cont_mode_ff;
				prdata[`QRPC_PA_DUM_L+3:`QRPC_PA_DUM_L]   <= dum_len;
				prdata[`QRPC_PA_WRAP_L+1:`QRPC_PA_WRAP_L] <= wrap_len_ff;
			end
			default:
				prdata <= 32'h00000000;
		endcase
	end
end

endmodule

//--- sim/qrpc_sva.sv
// Purpose: Port checks of the flash command controller.
// Assumes: Zero wait APB, link pins synchronised in pclk.
// Notes: Bound to qrpc_ctl.
`timescale 1ns/1ns
module qrpc_sva (
	// Clock and reset.
	input wire        pclk,
	input wire        presetn,
	// APB.
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// Link.
	input wire        cs_n,
	input wire [3:0]  dq_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rs = psel && !penable && !pwrite;
	wire bad = paddr != 8'h00 && paddr != 8'h04 && paddr != 8'h08;
	sequence idle4;
		cs_n [*4];
	endsequence
	sequence stat_rd;
		rs && paddr == 8'h00 ##1 prdata[4];
	endsequence
	AST_RDY: assert property (pready)
		else $error("pready low");
	AST_ERR: assert property (pslverr == (psel && penable && bad))
		else $error("pslverr wrong");
	AST_HOLD: assert property (!rs |=> $stable(prdata))
		else $error("prdata moved");
	AST_OE: assert property (dq_oe inside {4'h0, 4'h2, 4'hf})
		else $error("bad enable");
	AST_IDLE: assert property (idle4 |-> dq_oe == 4'h0)
		else $error("drive while idle");
	AST_START: assert property (idle4 ##1 !cs_n |->
		(dq_oe == 4'h0) [*8]) else $error("early drive");
	AST_DUM: assert property (rs && paddr == 8'h08 |=>
		prdata[27:24] inside {4'h2, 4'h4, 4'h6, 4'h8})
		else $error("bad dummy count");
	AST_BUSY: assert property (stat_rd |-> !prdata[2])
		else $error("mode kept in reset");
endmodule
bind qrpc_ctl qrpc_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .cs_n, .dq_oe);

//--- sim/qrpc_host.sv
// Purpose: Host serial controller model on the flash link.
// Assumes: 400 ns link clock that stands still between frames.
// Notes: Read data is sampled late in each low phase.
`timescale 1ns/1ns
module qrpc_host (
	// Link.
	output reg       cs_n,
	output reg       sclk,
	output reg [3:0] dq_in,
	input wire [3:0] dq_out
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		dq_in = 4'h0;
	end
	// Only whole commands are sent, and no array write is ever issued.
	task beg;
		#200 cs_n = 1'b0;
	endtask
	task fin;
		#200 cs_n = 1'b1;
		dq_in = ~dq_in;
		#2000;
	endtask
	task tx(input [7:0] b, input q, output [7:0] r);
		integer i;
		for (i = 0; i < (q ? 2 : 8); i = i + 1)
		begin
			dq_in = q ? (i ? b[3:0] : b[7:4]) : {dq_in[3:1], b[7 - i]};
			#240 r = q ? {r[3:0], dq_out} : {r[6:0], dq_out[1]};
			#10 sclk = 1'b1;
			#150 sclk = 1'b0;
		end
	endtask
endmodule

//--- sim/qrpc_ctl_tb.sv
// Purpose: Self-checking bench of the flash command controller.
// Assumes: 20 MHz pclk, 400 ns link clock.
// Notes: Array byte is the low address byte xor 5ah.
`timescale 1ns/1ns
module qrpc_ctl_tb;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire        cs_n;
	wire        sclk;
	wire [3:0]  dq_in;
	wire [3:0]  dq_out;
	wire [3:0]  dq_oe;
	// A line that is not driven shows the inverse of its last value.
	wire [3:0]  dq_bus = dq_out ^ ~dq_oe;
	wire [23:0] array_addr;
	wire [7:0]  array_data = array_addr[7:0] ^ 8'h5a;
	integer     miscompares = 0;
	integer     tests_run = 0;
	integer     cyc = 0;
	integer     i;
	reg  [31:0] d;
	reg  [7:0]  r;
	reg  [7:0]  p;
	always #25 pclk = ~pclk;
	qrpc_ctl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cs_n, .sclk, .dq_in,
		.dq_out, .dq_oe, .array_addr, .array_data);
	qrpc_host u_host (.cs_n, .sclk, .dq_in, .dq_out(dq_bus));
	task tally_and_finish;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input [31:0] s, input [31:0] e);
		tests_run = tests_run + 1;
		if (s !== e)
		begin
			miscompares = miscompares + 1;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		d = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rc(input [7:0] a, input [31:0] m, input [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(d & m, e);
	endtask
	task frm(input [7:0] op, input q, input integer n, input [7:0] b);
		u_host.beg;
		u_host.tx(op, q, r);
		repeat (n)
			u_host.tx(b, q, r);
		u_host.fin;
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			miscompares = miscompares + 1;
			tally_and_finish;
		end
	end
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rc(8'h08, 32'h3f0007ff, 32'h08000000);
		rc(8'h00, 32'h1f, 32'h0);
		frm(8'hc0, 1'b0, 1, 8'h31);
		rc(8'h08, 32'h3f0000ff, 32'h08000000);
		frm(8'h77, 1'b0, 4, 8'h20);
		frm(8'h06, 1'b0, 0, 8'h00);
		rc(8'h08, 32'h30000700, 32'h20000200);
		frm(8'h38, 1'b0, 0, 8'h00);
		rc(8'h00, 32'h6, 32'h6);
		rc(8'h08, 32'h30000000, 32'h20000000);
		for (i = 0; i < 17; i = i + 1)
		begin
			p = (i == 16) ? 8'h10 : {2'b00, i[3:2], 2'b00, i[1:0]};
			frm(8'hc0, 1'b1, 1, p);
			rc(8'h08, 32'h3f0000ff, {2'b00, p[1:0],
				4'h2 + {1'b0, p[5:4], 1'b0}, 16'h0, p});
		end
		u_host.beg;
		u_host.tx(8'h0c, 1'b1, r);
		repeat (5)
			u_host.tx(8'h05, 1'b1, r);
		for (i = 0; i < 10; i = i + 1)
		begin
			u_host.tx(8'h00, 1'b1, r);
			chk(r, {5'h0, i[2:0] + 3'h5} ^ 8'h5a);
		end
		u_host.fin;
		frm(8'hff, 1'b1, 0, 8'h00);
		rc(8'h00, 32'h6, 32'h2);
		rc(8'h08, 32'h30000000, 32'h0);
		u_host.beg;
		u_host.tx(8'h0b, 1'b0, r);
		repeat (4)
			u_host.tx(8'h20, 1'b0, r);
		for (i = 0; i < 2; i = i + 1)
		begin
			u_host.tx(8'h00, 1'b0, r);
			chk(r, (8'h20 + i[7:0]) ^ 8'h5a);
		end
		u_host.fin;
		u_host.beg;
		u_host.tx(8'heb, 1'b0, r);
		repeat (3)
			u_host.tx(8'h30, 1'b1, r);
		u_host.tx(8'ha5, 1'b1, r);
		repeat (2)
			u_host.tx(8'h00, 1'b1, r);
		u_host.tx(8'h00, 1'b1, r);
		chk(r, 8'h30 ^ 8'h5a);
		u_host.fin;
		rc(8'h08, 32'h0fff0000, 32'h06a50000);
		apb(1'b1, 8'h04, 32'h0000ab01);
		rc(8'h00, 32'h1, 32'h1);
		u_host.beg;
		u_host.tx(8'h05, 1'b0, r);
		u_host.tx(8'h00, 1'b0, r);
		chk(r, 8'hab);
		u_host.fin;
		apb(1'b1, 8'h04, 32'h0000ab00);
		rc(8'h00, 32'h1, 32'h0);
		frm(8'h04, 1'b0, 0, 8'h00);
		rc(8'h00, 32'h2, 32'h0);
		frm(8'h66, 1'b0, 0, 8'h00);
		frm(8'h06, 1'b0, 0, 8'h00);
		frm(8'h99, 1'b0, 0, 8'h00);
		rc(8'h00, 32'h1a, 32'h2);
		rc(8'h08, 32'hff, 32'h10);
		frm(8'h38, 1'b0, 0, 8'h00);
		frm(8'h66, 1'b1, 0, 8'h00);
		rc(8'h00, 32'h8, 32'h8);
		frm(8'h99, 1'b1, 0, 8'h00);
		rc(8'h00, 32'h1c, 32'h10);
		frm(8'h38, 1'b0, 0, 8'h00);
		repeat (700) @(posedge pclk);
		rc(8'h00, 32'h1e, 32'h0);
		rc(8'h04, 32'hffff, 32'h0);
		rc(8'h08, 32'h3fff07ff, 32'h08000000);
		frm(8'h38, 1'b0, 0, 8'h00);
		rc(8'h00, 32'h4, 32'h4);
		rc(8'h08, 32'h0f000000, 32'h02000000);
		rc(8'h0c, 32'hffffffff, 32'h0);
		tally_and_finish;
	end
endmodule
